// ---- rtl/scbe_pkg.sv ----
// scbe_pkg: shared constants and carriers for the call / branch-if-zero unit
// assumes a core that fetches 16-bit program words, one per instruction cycle
package scbe_pkg;
	// ----------------------------------------
	// encoding
	// ----------------------------------------
	localparam logic [3:0]  CALL_W1_PFX  = 4'hE;  // first-word prefix
	localparam logic [2:0]  CALL_W1_SUB  = 3'h6;  // bits 11:9 of word one
	localparam logic [3:0]  CALL_W2_PFX  = 4'hF;  // second-word prefix
	localparam logic [7:0]  BZ_OPC       = 8'hE0; // branch-if-zero high byte
	localparam int          SHADOW_BIT   = 8;     // shadow flag position
	// ----------------------------------------
	// widths and offsets
	// ----------------------------------------
	localparam int          PC_W         = 21;    // program counter width
	localparam logic [20:0] RET_OFS      = 21'h4; // return address offset
	localparam logic [20:0] SEQ_OFS      = 21'h2; // next-word offset
	localparam logic [20:0] PC_RST       = 21'h0; // pc after reset
	localparam logic [7:0]  REG_RST      = 8'h0;  // data regs after reset
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          OSC_PER_CYC  = 4;     // oscillator periods per cycle
	localparam logic [1:0]  PHASE_LAST   = 2'(OSC_PER_CYC - 1);

	// context saved by the shadow option
	typedef struct packed {
		logic [7:0] working;
		logic [7:0] flags;
		logic [7:0] bank_sel;
	} scbe_ctx_t;
endpackage

// ---- rtl/scbe_exec.sv ----
// scbe_exec: executes subroutine call and branch-if-zero
// assumes clk_i is the oscillator time base and instr_i is from the same domain
// Notes on behaviour
// RULE1: call pushes call address plus four
// RULE2: shadow flag one copies working, flags, bank
// RULE3: shadow flag zero keeps shadows unchanged
// RULE4: target loads pc bits twenty to one
// RULE5: full 20-bit target, one-bit shadow flag
// RULE6: call is two words, prefixes 1110/1111; the 1111 prefix of word two is not checked, any word after word one is taken
// RULE7: instruction cycle spans four oscillator periods
// RULE8: taken branch goes to pc plus two plus 2n
// RULE9: taken branch two cycles, untaken one
// RULE10: call takes three cycles, third idle
`timescale 1ns/1ps
`default_nettype none
module scbe_exec
(
	// clock, reset, enable
	input  wire  logic              clk_i,
	input  wire  logic              rstn_i,
	input  wire  logic              ce_i,
	// fetched words and core state
	input  wire  logic [15:0]       instr_i,
	input  wire  logic              zero_flag_i,
	input  wire  scbe_pkg::scbe_ctx_t ctx_i,
	// results
	output logic [20:0]             pc_o,
	output logic [20:0]             return_stack_top_o,
	output logic                    push_o,
	output scbe_pkg::scbe_ctx_t     shadow_o,
	output logic                    cycle_end_o,
	output logic                    idle_cycle_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		SCBE_EXEC  = 3'b001, // decode a fresh word
		SCBE_CALL2 = 3'b010, // second word of call
		SCBE_IDLE  = 3'b100  // forced no-operation cycle
	} scbe_st_t;

	scbe_st_t            st_r;        // sequencer state
	logic [1:0]          phase_r;     // oscillator phase in cycle
	logic [20:0]         pc_r;        // program counter
	logic [20:0]         tos_r;       // top of return stack
	logic                push_r;      // push pulse
	scbe_pkg::scbe_ctx_t shd_r;       // shadow registers
	logic [7:0]          lo_k_r;      // target bits 7:0 held
	logic                lo_s_r;      // shadow flag held
	logic [20:0]         call_pc_r;   // address of the call
	logic                end_r;       // last phase flag
	logic                idle_r;      // idle cycle flag
	logic                last_ph;     // cycle boundary
	logic                is_call1;    // call first word
	logic                is_bz;       // branch-if-zero word
	logic [20:0]         bz_tgt;      // branch target
	logic [20:0]         bz_ofs;      // doubled signed offset

	assign last_ph  = ce_i && (phase_r == scbe_pkg::PHASE_LAST);
	assign is_call1 = (instr_i[15:12] == scbe_pkg::CALL_W1_PFX) &&
	                  (instr_i[11:9] == scbe_pkg::CALL_W1_SUB); // RULE6
	assign is_bz    = (instr_i[15:8] == scbe_pkg::BZ_OPC);
	// sign-extended 2n added to incremented pc
	assign bz_ofs   = {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
	assign bz_tgt   = pc_r + scbe_pkg::SEQ_OFS + bz_ofs; // RULE8

	// ----------------------------------------
	// cycle phase counter
	// ----------------------------------------
	// four clock periods form one instruction cycle
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			phase_r <= 2'h0;
		else if (ce_i)
			phase_r <= phase_r + 2'h1; // RULE7
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			end_r <= 1'b0;
		else if (ce_i)
			end_r <= (phase_r == scbe_pkg::PHASE_LAST - 2'h1); // RULE7
	end

	// ----------------------------------------
	// sequencer and program counter
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_r      <= SCBE_EXEC;
			pc_r      <= scbe_pkg::PC_RST;
			lo_k_r    <= scbe_pkg::REG_RST;
			lo_s_r    <= 1'b0;
			call_pc_r <= scbe_pkg::PC_RST;
			idle_r    <= 1'b0;
		end
		else if (last_ph)
		begin
			unique case (st_r)
				SCBE_EXEC:
				begin
					idle_r <= 1'b0;
					pc_r   <= pc_r + scbe_pkg::SEQ_OFS;
					if (is_call1)
					begin
						// hold low target and flag for word two
						lo_k_r    <= instr_i[7:0];
						lo_s_r    <= instr_i[scbe_pkg::SHADOW_BIT]; // RULE5
						call_pc_r <= pc_r;
						st_r      <= SCBE_CALL2;
					end
					else if (is_bz && zero_flag_i)
					begin
						pc_r   <= bz_tgt; // RULE8
						st_r   <= SCBE_IDLE; // RULE9
						idle_r <= 1'b1; // RULE9
					end
				end
				SCBE_CALL2:
				begin
					// full 20-bit target, word aligned
					pc_r   <= {instr_i[11:0], lo_k_r, 1'b0}; // RULE4 RULE5
					st_r   <= SCBE_IDLE; // RULE10
					idle_r <= 1'b1;
				end
				SCBE_IDLE:
				begin
					// executed as no-operation; idle level drops with it
					st_r   <= SCBE_EXEC; // RULE9 RULE10
					idle_r <= 1'b0;
				end
				default:
				begin
					// illegal code: recover to decode, no idle
					st_r   <= SCBE_EXEC;
					idle_r <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// return stack and shadows
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tos_r  <= scbe_pkg::PC_RST;
			push_r <= 1'b0;
		end
		else if (ce_i)
		begin
			push_r <= 1'b0;
			if (last_ph && st_r == SCBE_CALL2)
			begin
				tos_r  <= call_pc_r + scbe_pkg::RET_OFS; // RULE1
				push_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			shd_r <= '0;
		else if (last_ph && st_r == SCBE_CALL2 && lo_s_r)
			shd_r <= ctx_i; // RULE2
		// flag zero: shadows hold, RULE3
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign pc_o               = pc_r;
	assign return_stack_top_o = tos_r;
	assign push_o             = push_r;
	assign shadow_o           = shd_r;
	assign cycle_end_o        = end_r;
	assign idle_cycle_o       = idle_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_push_value: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE1
		push_r |-> tos_r == $past(call_pc_r) + scbe_pkg::RET_OFS)
		else $error("return address wrong");
	// push may be held while ce_i is low, so look at its first clock only
	a_shadow_copy: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE2
		$rose(push_r) && $past(lo_s_r) |-> shd_r == $past(ctx_i))
		else $error("shadow copy missed");
	a_shadow_keep: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE3
		push_r && !$past(lo_s_r) |-> $stable(shd_r))
		else $error("shadow changed");
	a_target_load: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE4
		$rose(push_r) |-> pc_r[0] == 1'b0 && pc_r[8:1] == lo_k_r &&
		pc_r[20:9] == $past(instr_i[11:0]))
		else $error("call target wrong");
	a_phase_len: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE7
		end_r && ce_i |=> !end_r [*3])
		else $error("cycle not four periods");
	a_branch_tgt: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE8
		last_ph && st_r == SCBE_EXEC && is_bz && zero_flag_i && !is_call1
		|=> pc_r == $past(pc_r) + scbe_pkg::SEQ_OFS + $past(bz_ofs))
		else $error("branch target wrong");
	a_branch_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE9
		last_ph && st_r == SCBE_EXEC && is_bz && zero_flag_i
		|=> st_r == SCBE_IDLE && idle_r)
		else $error("taken branch lacks idle");
	// a branch not taken moves on in a single cycle
	a_untaken_one: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE9
		last_ph && st_r == SCBE_EXEC && is_bz && !zero_flag_i
		|=> st_r == SCBE_EXEC && pc_r == $past(pc_r) + scbe_pkg::SEQ_OFS)
		else $error("untaken branch not one cycle");
	// idle level mirrors the forced no-operation state
	a_idle_level: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE9
		idle_r == (st_r == SCBE_IDLE))
		else $error("idle level wrong");
	a_call_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE10
		push_r |-> st_r == SCBE_IDLE && idle_r)
		else $error("call lacks idle cycle");
	// push marks one enabled clock only
	a_push_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE1
		push_r && ce_i |=> !push_r)
		else $error("push held too long");
endmodule
`default_nettype wire

// ---- verif/scbe_exec_tb.sv ----
// scbe_exec_tb: self-checking bench for the call / branch-if-zero unit
// assumes the unit alone on a 250 MHz clock; the bench drives every port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	errors++; $display("FAIL %s exp %h got %h", nm, ex, got); end end
module scbe_exec_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic                clk_i = 1'b0;        // core clock
	logic                rstn_i = 1'b0;       // async reset, low active
	logic                ce_i = 1'b1;         // run enable
	logic [15:0]         instr_i = 16'h0000;  // program word
	logic                zero_flag_i = 1'b0;  // zero flag level
	scbe_pkg::scbe_ctx_t ctx_i = '0;          // live context
	logic [20:0]         pc_o;
	logic [20:0]         return_stack_top_o;
	logic                push_o;
	scbe_pkg::scbe_ctx_t shadow_o;
	logic                cycle_end_o;
	logic                idle_cycle_o;
	int                  errors = 0;          // mismatches
	int                  checked = 0;         // comparisons
	always #2 clk_i = ~clk_i;
	scbe_exec i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.instr_i(instr_i), .zero_flag_i(zero_flag_i), .ctx_i(ctx_i),
		.pc_o(pc_o), .return_stack_top_o(return_stack_top_o),
		.push_o(push_o), .shadow_o(shadow_o), .cycle_end_o(cycle_end_o),
		.idle_cycle_o(idle_cycle_o));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// prints the counts and the verdict, then ends the run
	task automatic stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// waits for the last phase, presents a word, lands after the edge
	task automatic issue(input logic [15:0] w);
		int n;
		n = 0;
		while (cycle_end_o !== 1'b1 && n < 9)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 9)
		begin
			errors++;
			stop_test();
		end
		instr_i = w;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// spacing between two instruction-cycle ends
	task automatic t_cycle;
		int n;
		issue(16'h0000);
		issue(16'h0000);
		// reach one cycle end, then count clocks to the next one
		n = 0;
		while (cycle_end_o !== 1'b1 && n < 9)
		begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end while (cycle_end_o !== 1'b1 && n < 9);
		`CHK("cycle len", scbe_pkg::OSC_PER_CYC, n)
		$display("test cycle done");
	endtask
	// enable low at a cycle end: nothing moves, the word is not taken
	task automatic t_freeze;
		logic [20:0] p;
		int          n;
		n = 0;
		while (cycle_end_o !== 1'b1 && n < 9)
		begin
			@(negedge clk_i);
			n++;
		end
		p = pc_o;
		zero_flag_i = 1'b1;
		instr_i = {scbe_pkg::BZ_OPC, 8'h10};
		ce_i = 1'b0;
		repeat (8) @(negedge clk_i);
		`CHK("frozen pc", p, pc_o)
		`CHK("frozen end", 1'b1, cycle_end_o)
		instr_i = 16'h0000;
		ce_i = 1'b1;
		@(negedge clk_i);
		`CHK("thawed pc", p + scbe_pkg::SEQ_OFS, pc_o)
		`CHK("thawed end", 1'b0, cycle_end_o)
		$display("test freeze done");
	endtask
	// branch-if-zero with flag z and offset n
	task automatic t_bz(input logic z, input logic [7:0] n);
		logic [20:0] ex;
		ex = pc_o + scbe_pkg::SEQ_OFS + (z ? {{12{n[7]}}, n, 1'b0} : 21'h0);
		zero_flag_i = z;
		issue({scbe_pkg::BZ_OPC, n});
		`CHK("bz pc", ex, pc_o)
		`CHK("bz idle", z, idle_cycle_o)
		`CHK("bz push", 1'b0, push_o)
		issue(16'h0000);
		`CHK("bz after", 1'b0, idle_cycle_o)
		$display("test bz %0d %h done", z, n);
	endtask
	// two-word call with shadow flag s and target k
	task automatic t_call(input logic s, input logic [19:0] k);
		logic [20:0]         a;
		scbe_pkg::scbe_ctx_t old;
		a = pc_o;
		old = shadow_o;
		ctx_i = {k[7:0], ~k[7:0], k[19:12]};
		issue({scbe_pkg::CALL_W1_PFX, scbe_pkg::CALL_W1_SUB, s, k[7:0]});
		`CHK("call w1 pc", a + scbe_pkg::SEQ_OFS, pc_o)
		`CHK("call w1 push", 1'b0, push_o)
		issue({scbe_pkg::CALL_W2_PFX, k[19:8]});
		`CHK("call pc", {k, 1'b0}, pc_o)
		`CHK("call tos", a + scbe_pkg::RET_OFS, return_stack_top_o)
		`CHK("call push", 1'b1, push_o)
		`CHK("call shadow", s ? ctx_i : old, shadow_o)
		`CHK("call idle", 1'b1, idle_cycle_o)
		@(negedge clk_i);
		`CHK("push pulse", 1'b0, push_o)
		// a taken branch word in the idle cycle must be ignored
		zero_flag_i = 1'b1;
		issue({scbe_pkg::BZ_OPC, 8'h10});
		`CHK("idle pc", {k, 1'b0}, pc_o)
		`CHK("call after", 1'b0, idle_cycle_o)
		$display("test call %0d %h done", s, k);
	endtask
	// reset in mid-run clears every output
	task automatic t_reset;
		rstn_i = 1'b0;
		@(negedge clk_i);
		`CHK("rst pc", scbe_pkg::PC_RST, pc_o)
		`CHK("rst tos", scbe_pkg::PC_RST, return_stack_top_o)
		`CHK("rst shadow", {3{scbe_pkg::REG_RST}}, shadow_o)
		`CHK("rst flags", 3'h0, {push_o, cycle_end_o, idle_cycle_o})
		rstn_i = 1'b1;
		$display("test reset done");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(negedge clk_i);
		`CHK("reset pc", scbe_pkg::PC_RST, pc_o)
		rstn_i = 1'b1;
		t_cycle();
		t_freeze();
		t_bz(1'b0, 8'h10);
		t_bz(1'b1, 8'h7F);
		t_bz(1'b1, 8'h80);
		t_call(1'b1, 20'hFFFFF);
		t_call(1'b0, 20'h00001);
		t_call(1'b1, 20'h5A5A5);
		t_reset();
		t_bz(1'b1, 8'hFE);
		stop_test();
	end
	// hang guard
	initial
	begin
		#40000;
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
